// ==== common/dtc_pkg.sv ====
// Shared constants, register map and carrier types of the DRAM timing configuration block.
package dtc_pkg;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned PRE_W = 12;

    localparam logic [ADDR_W-1:0] DMA_WAIT_ADDR = 32'hffff8626;
    localparam logic [ADDR_W-1:0] DRAM_CTRL_ADDR = 32'hffff862a;
    localparam logic [ADDR_W-1:0] RTCS_ADDR = 32'hffff862c;
    localparam logic [ADDR_W-1:0] REFRESH_CNT_ADDR = 32'hffff862e;
    localparam logic [ADDR_W-1:0] REFRESH_CONST_ADDR = 32'hffff8630;
    localparam logic [ADDR_W-1:0] EVT_STATUS_ADDR = 32'hffff8640;
    localparam logic [ADDR_W-1:0] EVT_MASK_ADDR = 32'hffff8642;

    localparam logic [DATA_W-1:0] DMA_WAIT_MASK = 16'h003f;
    localparam logic [DATA_W-1:0] DRAM_CTRL_MASK = 16'hffb7;
    localparam logic [DATA_W-1:0] RTCS_MASK = 16'h007f;
    localparam logic [DATA_W-1:0] DMA_WAIT_RST = 16'h000f;
    localparam logic [DATA_W-1:0] DRAM_CTRL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] RTCS_RST = 16'h0000;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

    localparam int unsigned DDW_LSB = 4;
    localparam int unsigned DSW_LSB = 0;
    localparam int unsigned TPC_BIT = 15;
    localparam int unsigned RCD_BIT = 14;
    localparam int unsigned REFRESH_ROW_ASSERT_LEN_LSB = 12;
    localparam int unsigned DWW_LSB = 10;
    localparam int unsigned DWR_LSB = 8;
    localparam int unsigned DIW_BIT = 7;
    localparam int unsigned BE_BIT = 5;
    localparam int unsigned ROW_STROBE_HOLD_MODE_BIT = 4;
    localparam int unsigned SZ_BIT = 2;
    localparam int unsigned AMX_LSB = 0;
    localparam int unsigned CMF_BIT = 6;
    localparam int unsigned MATCH_IRQ_ENABLE_BIT = 5;
    localparam int unsigned CKS_LSB = 2;
    localparam int unsigned REFRESH_ENABLE_BIT = 1;
    localparam int unsigned RMD_BIT = 0;

    localparam int unsigned EVT_W = 2;
    localparam int unsigned EVT_MATCH = 0;
    localparam int unsigned EVT_WRAP = 1;

    localparam logic [2:0] BASE_ACCESS_CYCLES = 3'h2;
    localparam logic [1:0] EXT_WAIT_MIN_CODE = 2'h2;
    localparam logic [3:0] PRECHARGE_SHORT_HALVES = 4'h3;
    localparam logic [3:0] PRECHARGE_LONG_HALVES = 4'h5;
    localparam logic [1:0] ROW_COL_SHORT_CYCLES = 2'h1;
    localparam logic [1:0] ROW_COL_LONG_CYCLES = 2'h2;
    localparam logic [3:0] REFRESH_ROW_ASSERT_LEN_BASE_HALVES = 4'h5;
    localparam logic [1:0] IDLE_CYCLES_ON = 2'h1;
    localparam logic [1:0] IDLE_CYCLES_OFF = 2'h0;
    localparam logic [DATA_W-1:0] CNT_ONE = 16'h0001;

    typedef enum logic [0:0] {
        DTC_CLR_IDLE = 1'b0,
        DTC_CLR_ARMED = 1'b1
    } dtc_clr_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dtc_bus_s;

    typedef struct packed {
        logic [2:0] read_cycles;
        logic read_ext_wait;
        logic [2:0] write_cycles;
        logic write_ext_wait;
        logic [2:0] dma_dram_cycles;
        logic dma_dram_ext_wait;
        logic [3:0] dma_cs_waits;
        logic dma_cs_ext_wait;
        logic [3:0] precharge_halves;
        logic [1:0] row_col_cycles;
        logic [3:0] refresh_ras_halves;
        logic [1:0] idle_cycles;
        logic page_burst;
        logic row_hold;
        logic width_word;
        logic [1:0] addr_mux;
        logic refresh_enable;
        logic refresh_kind;
    } dtc_timing_s;
endpackage

// ==== design/dtc_wait_decode.sv ====
// Decoder from a two-bit DRAM wait code to access length and external wait enable.
`timescale 1ns/10ps
module dtc_wait_decode
    import dtc_pkg::*;
(
    input wire logic [1:0] code,
    output logic [2:0] cycles,
    output logic ext_wait
);
    // The two shorter settings are fixed length; only the longer two honour external wait.
    always_comb
    begin
        cycles = BASE_ACCESS_CYCLES + {1'b0, code};
        ext_wait = (code >= EXT_WAIT_MIN_CODE);
    end
endmodule

// ==== design/dtc_prescaler.sv ====
// Refresh counter clock prescaler producing a one-cycle count enable.
`timescale 1ns/10ps
module dtc_prescaler
    import dtc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [PRE_W-1:0] div;
    logic [PRE_W-1:0] next_div;
    logic next_tick;

    function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] s);
        case (s)
            3'h1: div_mask = 12'h001;
            3'h2: div_mask = 12'h007;
            3'h3: div_mask = 12'h01f;
            3'h4: div_mask = 12'h07f;
            3'h5: div_mask = 12'h1ff;
            3'h6: div_mask = 12'h7ff;
            3'h7: div_mask = 12'hfff;
            default: div_mask = 12'h000;
        endcase
    endfunction

    // The divider runs free, so a change of ratio may shorten the first period after it.
    always_comb
    begin
        next_div = div + 12'h001;
        next_tick = (sel != 3'h0) && ((div & div_mask(sel)) == div_mask(sel));
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div <= 12'h000;
            tick <= 1'b0;
        end
        else
        begin
            div <= next_div;
            tick <= next_tick;
        end
    end
endmodule

// ==== design/dtc_top.sv ====
// DRAM timing configuration registers, refresh timer and interrupt logic.
`timescale 1ns/10ps
module dtc_top
    import dtc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dtc_bus_s bus,
    output logic [DATA_W-1:0] rd_data,
    output dtc_timing_s timing,
    output logic refresh_req,
    output logic irq
);
    logic [DATA_W-1:0] dma_single_wait_ctrl;
    logic [DATA_W-1:0] dram_area_ctrl;
    logic [DATA_W-1:0] refresh_timer_ctrl_status;
    logic [DATA_W-1:0] refresh_counter;
    logic [DATA_W-1:0] refresh_constant;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
    logic touched;
    logic match_q;
    dtc_clr_e clr_state;

    logic [DATA_W-1:0] next_dma_single_wait_ctrl;
    logic [DATA_W-1:0] next_dram_area_ctrl;
    logic [DATA_W-1:0] next_refresh_timer_ctrl_status;
    logic [DATA_W-1:0] next_refresh_counter;
    logic [DATA_W-1:0] next_refresh_constant;
    logic [EVT_W-1:0] next_evt_status;
    logic [EVT_W-1:0] next_evt_mask;
    logic next_touched;
    logic next_match_q;
    dtc_clr_e next_clr_state;
    logic [DATA_W-1:0] next_rd_data;
    dtc_timing_s next_timing;
    logic next_refresh_req;
    logic next_irq;

    logic tick;
    logic match_now;
    logic match_rise;
    logic wrap_evt;
    logic flag_clear;
    logic [2:0] rd_cycles;
    logic rd_ext;
    logic [2:0] wr_cycles;
    logic wr_ext;
    logic [2:0] dma_cycles;
    logic dma_ext;
    logic flag_irq;
    logic evt_irq;

    function automatic logic hit(input dtc_bus_s b, input logic [ADDR_W-1:0] a);
        hit = (b.addr == a);
    endfunction

    dtc_prescaler u_prescaler (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sel(refresh_timer_ctrl_status[CKS_LSB+:3]),
        .tick(tick)
    );

    dtc_wait_decode u_read_wait (
        .code(dram_area_ctrl[DWR_LSB+:2]),
        .cycles(rd_cycles),
        .ext_wait(rd_ext)
    );

    dtc_wait_decode u_write_wait (
        .code(dram_area_ctrl[DWW_LSB+:2]),
        .cycles(wr_cycles),
        .ext_wait(wr_ext)
    );

    dtc_wait_decode u_dma_wait (
        .code(dma_single_wait_ctrl[DDW_LSB+:2]),
        .cycles(dma_cycles),
        .ext_wait(dma_ext)
    );

    // Register file, refresh counter and flag handling.
    always_comb
    begin
        next_dma_single_wait_ctrl = dma_single_wait_ctrl;
        next_dram_area_ctrl = dram_area_ctrl;
        next_refresh_timer_ctrl_status = refresh_timer_ctrl_status;
        next_refresh_counter = refresh_counter;
        next_refresh_constant = refresh_constant;
        next_evt_mask = evt_mask;
        next_touched = touched;
        next_clr_state = clr_state;

        // Untouched zero registers compare equal, so the match is qualified.
        match_now = touched && (refresh_counter == refresh_constant);
        match_rise = match_now && !match_q;
        next_match_q = match_now;
        wrap_evt = 1'b0;

        if (tick)
        begin
            next_touched = 1'b1;
            if (match_now)
            begin
                next_refresh_counter = ZERO_WORD;
            end
            else
            begin
                next_refresh_counter = refresh_counter + CNT_ONE;
                wrap_evt = (refresh_counter == ~ZERO_WORD);
            end
        end

        flag_clear = 1'b0;
        if (bus.rd && hit(bus, RTCS_ADDR) && refresh_timer_ctrl_status[CMF_BIT])
        begin
            next_clr_state = DTC_CLR_ARMED;
        end

        if (bus.wr)
        begin
            if (hit(bus, DMA_WAIT_ADDR))
            begin
                next_dma_single_wait_ctrl = bus.wdata & DMA_WAIT_MASK;
            end
            if (hit(bus, DRAM_CTRL_ADDR))
            begin
                next_dram_area_ctrl = bus.wdata & DRAM_CTRL_MASK;
            end
            if (hit(bus, RTCS_ADDR))
            begin
                // The flag itself cannot be written to one; besides a match, only the clear sequence touches it.
                next_refresh_timer_ctrl_status = (bus.wdata & RTCS_MASK)
                    | (refresh_timer_ctrl_status & (CNT_ONE << CMF_BIT));
                next_refresh_timer_ctrl_status[CMF_BIT] = refresh_timer_ctrl_status[CMF_BIT];
                if (!bus.wdata[CMF_BIT] && (clr_state == DTC_CLR_ARMED))
                begin
                    flag_clear = 1'b1;
                end
                next_clr_state = DTC_CLR_IDLE;
            end
            if (hit(bus, REFRESH_CNT_ADDR))
            begin
                next_refresh_counter = bus.wdata;
                next_touched = 1'b1;
            end
            if (hit(bus, REFRESH_CONST_ADDR))
            begin
                next_refresh_constant = bus.wdata;
                next_touched = 1'b1;
            end
            if (hit(bus, EVT_MASK_ADDR))
            begin
                next_evt_mask = bus.wdata[EVT_W-1:0];
            end
        end

        // A match in the clearing cycle keeps the flag set.
        if (flag_clear)
        begin
            next_refresh_timer_ctrl_status[CMF_BIT] = 1'b0;
        end
        if (match_rise)
        begin
            next_refresh_timer_ctrl_status[CMF_BIT] = 1'b1;
        end

        next_evt_status = evt_status;
        if (bus.rd && hit(bus, EVT_STATUS_ADDR))
        begin
            next_evt_status = '0;
        end
        next_evt_status[EVT_MATCH] = next_evt_status[EVT_MATCH] | match_rise;
        next_evt_status[EVT_WRAP] = next_evt_status[EVT_WRAP] | wrap_evt;
    end

    // The interrupt follows the next flag state so its flop moves with the flags; the refresh request uses the match edge and the current enable bit.
    always_comb
    begin
        flag_irq = next_refresh_timer_ctrl_status[CMF_BIT]
            && next_refresh_timer_ctrl_status[MATCH_IRQ_ENABLE_BIT];
        evt_irq = (next_evt_status & next_evt_mask) != '0;
        next_refresh_req = match_rise && refresh_timer_ctrl_status[REFRESH_ENABLE_BIT];
        next_irq = flag_irq || evt_irq;
    end

    // Read mux; unmapped addresses and reserved bits answer zero.
    always_comb
    begin
        next_rd_data = ZERO_WORD;
        if (bus.rd)
        begin
            if (hit(bus, DMA_WAIT_ADDR))
            begin
                next_rd_data = dma_single_wait_ctrl & DMA_WAIT_MASK;
            end
            else if (hit(bus, DRAM_CTRL_ADDR))
            begin
                next_rd_data = dram_area_ctrl & DRAM_CTRL_MASK;
            end
            else if (hit(bus, RTCS_ADDR))
            begin
                next_rd_data = refresh_timer_ctrl_status & RTCS_MASK;
            end
            else if (hit(bus, REFRESH_CNT_ADDR))
            begin
                next_rd_data = refresh_counter;
            end
            else if (hit(bus, REFRESH_CONST_ADDR))
            begin
                next_rd_data = refresh_constant;
            end
            else if (hit(bus, EVT_STATUS_ADDR))
            begin
                next_rd_data = {{(DATA_W-EVT_W){1'b0}}, evt_status};
            end
            else if (hit(bus, EVT_MASK_ADDR))
            begin
                next_rd_data = {{(DATA_W-EVT_W){1'b0}}, evt_mask};
            end
            else
            begin
                next_rd_data = ZERO_WORD;
            end
        end
    end

    // Timing view handed to the access sequencer.
    always_comb
    begin
        next_timing.read_cycles = rd_cycles;
        next_timing.read_ext_wait = rd_ext;
        next_timing.write_cycles = wr_cycles;
        next_timing.write_ext_wait = wr_ext;
        next_timing.dma_dram_cycles = dma_cycles;
        next_timing.dma_dram_ext_wait = dma_ext;
        next_timing.dma_cs_waits = dma_single_wait_ctrl[DSW_LSB+:4];
        next_timing.dma_cs_ext_wait = (dma_single_wait_ctrl[DSW_LSB+:4] != 4'h0);
        // Half-cycle units keep the odd figures exact.
        next_timing.precharge_halves = dram_area_ctrl[TPC_BIT] ? PRECHARGE_LONG_HALVES
            : PRECHARGE_SHORT_HALVES;
        next_timing.row_col_cycles = dram_area_ctrl[RCD_BIT] ? ROW_COL_LONG_CYCLES
            : ROW_COL_SHORT_CYCLES;
        next_timing.refresh_ras_halves = REFRESH_ROW_ASSERT_LEN_BASE_HALVES
            + {1'b0, dram_area_ctrl[REFRESH_ROW_ASSERT_LEN_LSB+:2], 1'b0};
        next_timing.idle_cycles = dram_area_ctrl[DIW_BIT] ? IDLE_CYCLES_ON
            : IDLE_CYCLES_OFF;
        next_timing.page_burst = dram_area_ctrl[BE_BIT];
        next_timing.row_hold = dram_area_ctrl[ROW_STROBE_HOLD_MODE_BIT];
        next_timing.width_word = dram_area_ctrl[SZ_BIT];
        next_timing.addr_mux = dram_area_ctrl[AMX_LSB+:2];
        next_timing.refresh_enable = refresh_timer_ctrl_status[REFRESH_ENABLE_BIT];
        next_timing.refresh_kind = refresh_timer_ctrl_status[RMD_BIT];
    end

    // Register file state.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dma_single_wait_ctrl <= DMA_WAIT_RST;
            dram_area_ctrl <= DRAM_CTRL_RST;
            refresh_timer_ctrl_status <= RTCS_RST;
            refresh_counter <= ZERO_WORD;
            refresh_constant <= ZERO_WORD;
            evt_status <= '0;
            evt_mask <= '0;
            touched <= 1'b0;
            match_q <= 1'b0;
            clr_state <= DTC_CLR_IDLE;
        end
        else
        begin
            dma_single_wait_ctrl <= next_dma_single_wait_ctrl;
            dram_area_ctrl <= next_dram_area_ctrl;
            refresh_timer_ctrl_status <= next_refresh_timer_ctrl_status;
            refresh_counter <= next_refresh_counter;
            refresh_constant <= next_refresh_constant;
            evt_status <= next_evt_status;
            evt_mask <= next_evt_mask;
            touched <= next_touched;
            match_q <= next_match_q;
            clr_state <= next_clr_state;
        end
    end

    // Request outputs.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            refresh_req <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            refresh_req <= next_refresh_req;
            irq <= next_irq;
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= ZERO_WORD;
        end
        else
        begin
            rd_data <= next_rd_data;
        end
    end

    // The timing view trails the registers by one edge so the sequencer never sees a torn word.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timing <= '0;
        end
        else
        begin
            timing <= next_timing;
        end
    end
endmodule

// ==== dv/dtc_checker.sv ====
// Concurrent checks on the ports of the DRAM timing configuration block.
`timescale 1ns/10ps
module dtc_checker
    import dtc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dtc_bus_s bus,
    input wire logic [DATA_W-1:0] rd_data,
    input wire dtc_timing_s timing,
    input wire logic refresh_req,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Timing outputs lag a register write by two edges, so each timing check looks two cycles ahead.
    read_wait_a: assert property (
        bus.wr && bus.addr == DRAM_CTRL_ADDR |-> ##2
        timing.read_cycles == 3'h2 + {1'b0, $past(bus.wdata[9:8], 2)}
        && timing.read_ext_wait == $past(bus.wdata[9], 2))
        else $error("read wait mismatch");
    write_wait_a: assert property (
        bus.wr && bus.addr == DRAM_CTRL_ADDR |-> ##2
        timing.write_cycles == 3'h2 + {1'b0, $past(bus.wdata[11:10], 2)}
        && timing.write_ext_wait == $past(bus.wdata[11], 2))
        else $error("write wait mismatch");
    dma_dram_a: assert property (
        bus.wr && bus.addr == DMA_WAIT_ADDR |-> ##2
        timing.dma_dram_cycles == 3'h2 + {1'b0, $past(bus.wdata[5:4], 2)}
        && timing.dma_dram_ext_wait == $past(bus.wdata[5], 2))
        else $error("dma dram wait mismatch");
    dma_cs_a: assert property (
        bus.wr && bus.addr == DMA_WAIT_ADDR |-> ##2
        timing.dma_cs_waits == $past(bus.wdata[3:0], 2)
        && timing.dma_cs_ext_wait == ($past(bus.wdata[3:0], 2) != 4'h0))
        else $error("dma cs wait mismatch");
    precharge_delay_a: assert property (
        bus.wr && bus.addr == DRAM_CTRL_ADDR |-> ##2
        timing.precharge_halves == ($past(bus.wdata[15], 2) ? 4'h5 : 4'h3)
        && timing.row_col_cycles == ($past(bus.wdata[14], 2) ? 2'h2 : 2'h1))
        else $error("precharge mismatch");
    refresh_ras_a: assert property (
        bus.wr && bus.addr == DRAM_CTRL_ADDR |-> ##2
        timing.refresh_ras_halves == 4'h5 + {1'b0, $past(bus.wdata[13:12], 2), 1'b0})
        else $error("refresh strobe mismatch");
    mode_bits_a: assert property (
        bus.wr && bus.addr == DRAM_CTRL_ADDR |-> ##2
        timing.idle_cycles == {1'b0, $past(bus.wdata[7], 2)}
        && {timing.page_burst, timing.row_hold} == $past(bus.wdata[5:4], 2))
        else $error("mode bits mismatch");
    read_idle_a: assert property (
        !$past(bus.rd) |-> rd_data == 16'h0000)
        else $error("read data without read");
    status_rsvd_a: assert property (
        bus.rd && bus.addr == RTCS_ADDR |=> rd_data[15:7] == 9'h000)
        else $error("status reserved bits set");
    refresh_pulse_a: assert property (
        refresh_req |=> !refresh_req)
        else $error("refresh request too long");
endmodule

// ==== dv/dtc_dram_model.sv ====
// Far-side DRAM model that turns the timing settings into a read access length.
`timescale 1ns/10ps
module dtc_dram_model
    import dtc_pkg::*;
#(
    parameter logic [3:0] STALL = 4'h2
)
(
    input wire dtc_timing_s timing,
    output logic [3:0] read_len
);
    // The model always holds its wait line for STALL cycles; only enabled settings see it.
    assign read_len = {1'b0, timing.read_cycles} + (timing.read_ext_wait ? STALL : 4'h0);
endmodule

// ==== dv/test_dram_timing_config.sv ====
// Self-checking testbench of the DRAM timing configuration block.
`timescale 1ns/10ps
module test_dram_timing_config
    import dtc_pkg::*;
;
    logic ref_clk;
    logic rst_n;
    dtc_bus_s bus;
    logic [DATA_W-1:0] rd_data;
    dtc_timing_s timing;
    logic refresh_req;
    logic irq;
    logic [3:0] read_len;
    int errors;
    int samples_checked;
    int pulses = 0;
    logic [15:0] ctrl;
    logic [15:0] dma;
    logic [15:0] a;
    logic [15:0] b;
    int divs[8] = '{16, 2, 8, 32, 128, 512, 2048, 4096};

    dtc_top u_dtc_top (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
        .timing(timing), .refresh_req(refresh_req), .irq(irq));
    dtc_dram_model u_dtc_dram_model (.timing(timing), .read_len(read_len));

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
        if (refresh_req === 1'b1)
            pulses <= pulses + 1;

    task automatic finish_test;
        if (errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Each access ends one nanosecond past its last edge, so registered results have landed.
    task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] v);
        @(posedge ref_clk);
        bus <= '{addr: ad, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
        #1;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] ad, output logic [DATA_W-1:0] v);
        @(posedge ref_clk);
        bus <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1 v = rd_data;
    endtask

    task automatic rdchk(input string name, input logic [ADDR_W-1:0] ad, input logic [15:0] e);
        logic [15:0] v;
        rd(ad, v);
        chk(name, v, e);
    endtask

    function automatic dtc_timing_s exp_t(input logic [15:0] c, input logic [15:0] w,
        input logic [15:0] r);
        dtc_timing_s t;
        t.read_cycles = 3'h2 + {1'b0, c[9:8]};
        t.read_ext_wait = c[9];
        t.write_cycles = 3'h2 + {1'b0, c[11:10]};
        t.write_ext_wait = c[11];
        t.dma_dram_cycles = 3'h2 + {1'b0, w[5:4]};
        t.dma_dram_ext_wait = w[5];
        t.dma_cs_waits = w[3:0];
        t.dma_cs_ext_wait = |w[3:0];
        t.precharge_halves = c[15] ? 4'h5 : 4'h3;
        t.row_col_cycles = c[14] ? 2'h2 : 2'h1;
        t.refresh_ras_halves = 4'h5 + {1'b0, c[13:12], 1'b0};
        t.idle_cycles = {1'b0, c[7]};
        t.page_burst = c[5];
        t.row_hold = c[4];
        t.width_word = c[2];
        t.addr_mux = c[1:0];
        t.refresh_enable = r[1];
        t.refresh_kind = r[0];
        return t;
    endfunction

    task automatic test_reset;
        rdchk("dma wait", DMA_WAIT_ADDR, 16'h000f);
        rdchk("dram ctrl", DRAM_CTRL_ADDR, 16'h0000);
        rdchk("timer status", RTCS_ADDR, 16'h0000);
        chk("timing", timing, exp_t(16'h0000, 16'h000f, 16'h0000));
        wr(32'hffff8628, 16'hffff);
        rdchk("unmapped", 32'hffff8628, 16'h0000);
        rdchk("dram ctrl", DRAM_CTRL_ADDR, 16'h0000);
    endtask

    task automatic test_ctrl;
        for (int i = 0; i < 4; i++)
        begin
            ctrl = 16'h5555 * i[15:0];
            wr(DRAM_CTRL_ADDR, ctrl);
            // The timing view lands one edge after the register itself.
            @(posedge ref_clk);
            #1;
            chk("timing", timing, exp_t(ctrl, 16'h000f, 16'h0000));
            chk("read length", read_len, 4'h2 + i[3:0] + (i > 1 ? 4'h2 : 4'h0));
            rdchk("dram ctrl", DRAM_CTRL_ADDR, ctrl & 16'hffb7);
        end
    endtask

    task automatic test_dma;
        for (int i = 0; i < 4; i++)
        begin
            dma = 16'h5555 * i[15:0];
            wr(DMA_WAIT_ADDR, dma);
            @(posedge ref_clk);
            #1;
            chk("timing", timing, exp_t(ctrl, dma, 16'h0000));
            rdchk("dma wait", DMA_WAIT_ADDR, dma & 16'h003f);
        end
    endtask

    // A window that is a whole number of divider periods always holds the same tick count.
    task automatic test_divider;
        wr(REFRESH_CONST_ADDR, 16'hffff);
        for (int i = 0; i < 8; i++)
        begin
            wr(RTCS_ADDR, {11'h000, i[2:0], 2'b00});
            wr(REFRESH_CNT_ADDR, 16'h0000);
            rd(REFRESH_CNT_ADDR, a);
            repeat (2 * divs[i] - 2) @(posedge ref_clk);
            rd(REFRESH_CNT_ADDR, b);
            chk("count step", b - a, (i == 0) ? 16'h0000 : 16'h0002);
        end
        chk("refresh pulses", pulses, 0);
    endtask

    task automatic test_match;
        // Clear the counter before the constant so a stale count cannot match early.
        wr(REFRESH_CNT_ADDR, 16'h0000);
        wr(REFRESH_CONST_ADDR, 16'h0003);
        wr(RTCS_ADDR, 16'h0026);
        repeat (64)
        begin
            @(posedge ref_clk);
            #1;
            if (irq === 1'b1)
                break;
        end
        chk("irq", irq, 1'b1);
        wr(RTCS_ADDR, 16'h0002);
        chk("refresh pulse", pulses != 0, 1'b1);
        chk("irq", irq, 1'b0);
        wr(RTCS_ADDR, 16'h0022);
        chk("irq", irq, 1'b1);
        rdchk("timer status", RTCS_ADDR, 16'h0062);
        wr(RTCS_ADDR, 16'h0020);
        chk("irq", irq, 1'b0);
        rdchk("timer status", RTCS_ADDR, 16'h0020);
        wr(EVT_MASK_ADDR, 16'h0001);
        chk("irq", irq, 1'b1);
        rdchk("event status", EVT_STATUS_ADDR, 16'h0001);
        @(posedge ref_clk);
        #1;
        chk("irq", irq, 1'b0);
        rdchk("event status", EVT_STATUS_ADDR, 16'h0000);
        wr(RTCS_ADDR, 16'h0003);
        @(posedge ref_clk);
        #1;
        chk("timing", timing, exp_t(ctrl, dma, 16'h0003));
    endtask

    initial
    begin
        errors = 0;
        samples_checked = 0;
        bus = '0;
        rst_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_reset;
        test_ctrl;
        test_dma;
        test_divider;
        test_match;
        finish_test;
    end

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        errors++;
        finish_test;
    end
endmodule

bind dtc_top dtc_checker u_dtc_checker (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
    .rd_data(rd_data), .timing(timing), .refresh_req(refresh_req), .irq(irq));
